// file: hdl/rsa_fifo.sv
// Purpose: Transmit byte FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Flush empties it in one cycle
`timescale 1ns/100ps
module rsa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  // Fill level
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } rsa_fifo_st_t;
  rsa_fifo_st_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             wr, rd;

  // ===========================================================
  // Handshakes and pointers
  assign in_ready_o  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o  = mem[s_q.rp];
  assign count_o     = s_q.cnt;
  assign wr          = in_valid_i && in_ready_o;
  assign rd          = out_valid_o && out_ready_i;

  // Next pointer state
  always_comb begin
    s_d = s_q;
    if (wr) s_d.wp = s_q.wp + 1'b1;
    if (rd) s_d.rp = s_q.rp + 1'b1;
    s_d.cnt = s_q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    if (flush_i) s_d = '0;
  end

  // State register and storage
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) s_q <= '0;
    else s_q <= s_d;
    if (wr) mem[s_q.wp] <= in_data_i;
  end
endmodule

// file: hdl/rsa_pkg.sv
// Purpose: Shared constants and types for the radio serial register port
// Assumes: One core clock; serial pins are sampled by it
// Notes:   Header byte is direction, burst, six address bits
package rsa_pkg;
  // ===========================================================
  // Header layout and address map
  localparam int          HDR_DIR_BIT    = 7;
  localparam int          HDR_BURST_BIT  = 6;
  localparam logic [5:0]  CFG_LAST_ADDR  = 6'h2f;
  localparam logic [5:0]  STROBE_FIRST   = 6'h30;
  localparam logic [5:0]  STROBE_LAST    = 6'h3d;
  localparam logic [5:0]  PWR_TABLE_ADDR = 6'h3e;
  localparam logic [5:0]  TX_FIFO_ADDR   = 6'h3f;
  // ===========================================================
  // Strobe codes in the strobe range
  localparam logic [5:0]  CHIP_RESET_STROBE  = 6'h30;
  localparam logic [5:0]  POWER_DOWN_STROBE  = 6'h36;
  localparam logic [5:0]  CRYSTAL_OFF_STROBE = 6'h32;
  localparam logic [5:0]  FLUSH_TX_STROBE    = 6'h3b;
  localparam logic [5:0]  SLEEP_REG_ADDR     = 6'h35;
  // ===========================================================
  // Sizes and reset values
  localparam int          TX_FIFO_DEPTH  = 64;
  localparam int          CFG_REGS       = 48;
  localparam int          PWR_ENTRIES    = 8;
  localparam logic [3:0]  FREE_SAT       = 4'hf;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [7:0]  PWR_RESET      = 8'h00;
  localparam logic [2:0]  STATE_IDLE     = 3'h0;
  localparam logic [2:0]  STATE_SLEEP    = 3'h0;
  localparam int          RST_BUSY_NS    = 100;
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          RST_BUSY_CYC   = (RST_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    RSA_HDR, RSA_CFG, RSA_STAT, RSA_FIFO, RSA_PWR, RSA_IGNORE
  } rsa_phase_t;
endpackage

// file: hdl/rsa_spi_port.sv
// Purpose: Serial register port of a low-power radio transmitter (slave side)
// Assumes: Serial clock slow against core clock; pins pass two flops
// Notes:   Mode 0: data sampled on rising, shifted on falling serial clock
`timescale 1ns/100ps
module rsa_spi_port
  import rsa_pkg::*;
#(
  parameter int FIFO_DEPTH = rsa_pkg::TX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  // Serial pins
  input  wire logic       sclk_i,
  input  wire logic       select_low_i,
  input  wire logic       sdi_i,
  output logic            shared_status_out_pin_o,
  output logic            shared_status_out_pin_oe_o,
  // Radio core side
  input  wire logic       core_stable_i,
  input  wire logic [2:0] main_state_i,
  input  wire logic [7:0] status_reg_val_i,
  output logic            tx_valid_o,
  input  wire logic       tx_ready_i,
  output logic [7:0]      tx_data_o,
  output logic [2:0]      power_index_field_o,
  output logic [7:0]      power_level_o,
  output logic            strobe_o,
  output logic [5:0]      strobe_code_o,
  output logic            sleep_o,
  output logic [5:0]      status_addr_o
);
  // ===========================================================
  // State
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] sel_s;
    logic [1:0] sdi_s;
    rsa_phase_t ph;
    logic       dir;
    logic       burst;
    logic [5:0] addr;
    logic [2:0] bitn;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic       so;
    logic       oe;
    logic [2:0] pidx;
    logic       defer_pd;
    logic       defer_xo;
    logic       strobe;
    logic [5:0] scode;
    logic       sleep;
    logic       reset_busy;
    logic [7:0] busy_cnt;
    logic       fifo_push;
    logic [7:0] fifo_byte;
    logic       flush;
    logic       tx_v;
    logic [7:0] tx_d;
    logic [7:0] plevel;
  } rsa_st_t;
  rsa_st_t s_q, s_d;
  logic [7:0] cfg_q [CFG_REGS];
  logic [7:0] pwr_q [PWR_ENTRIES];
  logic       cfg_we, pwr_we, sleep_entry;
  logic [7:0] wdata;
  logic       f_ready, f_valid;
  logic [7:0] f_data;
  logic [$clog2(FIFO_DEPTH):0] f_cnt;
  logic       rise, fall, sel_n;

  // Status byte from readiness, state and free space
  function automatic logic [7:0] status_byte(input logic rdy, input logic [2:0] st,
                                             input logic [$clog2(FIFO_DEPTH):0] cnt);
    logic [$clog2(FIFO_DEPTH):0] free;
    free = ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH) - cnt;
    status_byte = {~rdy, st, (free > 15) ? FREE_SAT : free[3:0]};
  endfunction

  // ===========================================================
  // Transmit FIFO
  rsa_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .flush_i    (s_q.flush),
    .in_valid_i (s_q.fifo_push),
    .in_ready_o (f_ready),
    .in_data_i  (s_q.fifo_byte),
    .out_valid_o(f_valid),
    .out_ready_i(tx_ready_i && !s_q.tx_v),
    .out_data_o (f_data),
    .count_o    (f_cnt)
  );

  // Edge detection on synchronised pins (stage 0 read only by stage 1)
  assign rise  = s_q.sclk_s[1] && !s_q.sclk_s[2];
  assign fall  = !s_q.sclk_s[1] && s_q.sclk_s[2];
  assign sel_n = s_q.sel_s[1];
  assign wdata = {s_q.sh_in[6:0], s_q.sdi_s[1]};
  assign sleep_entry = s_d.sleep && !s_q.sleep;

  // ===========================================================
  // Serial protocol engine
  always_comb begin
    s_d        = s_q;
    cfg_we     = 1'b0;
    pwr_we     = 1'b0;
    s_d.strobe = 1'b0;
    s_d.flush  = 1'b0;
    s_d.fifo_push = 1'b0;
    s_d.sclk_s = {s_q.sclk_s[1:0], sclk_i};
    s_d.sel_s  = {s_q.sel_s[0], select_low_i};
    s_d.sdi_s  = {s_q.sdi_s[0], sdi_i};
    if (s_q.tx_v && tx_ready_i) s_d.tx_v = 1'b0;
    if (!s_q.tx_v && f_valid && tx_ready_i) begin
      s_d.tx_v = 1'b1;
      s_d.tx_d = f_data;
    end
    if (s_q.reset_busy) begin
      s_d.busy_cnt = s_q.busy_cnt - 8'h01;
      if (s_q.busy_cnt == 8'h00) s_d.reset_busy = 1'b0;
    end
    if (sel_n) begin
      // Select high ends any access; one deferred strobe fires now, power-down taking precedence over crystal-off
      s_d.ph   = RSA_HDR;
      s_d.bitn = 3'h0;
      s_d.pidx = 3'h0;
      s_d.oe   = 1'b0;
      if (s_q.defer_pd || s_q.defer_xo) begin
        s_d.strobe   = 1'b1;
        s_d.scode    = s_q.defer_pd ? POWER_DOWN_STROBE : CRYSTAL_OFF_STROBE;
        s_d.sleep    = s_q.defer_pd;
        s_d.defer_pd = 1'b0;
        s_d.defer_xo = 1'b0;
      end
      s_d.sh_out = status_byte(core_stable_i, s_q.sleep ? STATE_SLEEP : main_state_i, f_cnt);
      s_d.so     = s_d.sh_out[7];
    end else begin
      s_d.oe    = 1'b1;
      if (s_q.ph == RSA_HDR && s_q.bitn == 3'h0 && !rise) begin
        s_d.sh_out = status_byte(core_stable_i, main_state_i, f_cnt);
        s_d.so     = s_q.reset_busy ? 1'b1 : s_d.sh_out[7];
      end
      if (rise) begin
        s_d.sh_in = wdata;
        s_d.bitn  = s_q.bitn + 3'h1;
      end
      if (fall && s_q.bitn != 3'h0) begin
        s_d.sh_out = {s_q.sh_out[6:0], 1'b0};
        s_d.so     = s_q.sh_out[6];
      end
      if (rise && s_q.bitn == 3'h7) begin
        // Complete byte received
        s_d.sh_out = status_byte(core_stable_i, main_state_i, f_cnt);
        case (s_q.ph)
          RSA_HDR: begin
            s_d.dir   = wdata[HDR_DIR_BIT];
            s_d.burst = wdata[HDR_BURST_BIT];
            s_d.addr  = wdata[5:0];
            if (wdata[5:0] <= CFG_LAST_ADDR) begin
              s_d.ph = RSA_CFG;
              if (wdata[HDR_DIR_BIT]) s_d.sh_out = cfg_q[wdata[5:0]];
            end else if (wdata[5:0] == TX_FIFO_ADDR) begin
              s_d.ph = wdata[HDR_DIR_BIT] ? RSA_IGNORE : RSA_FIFO;
            end else if (wdata[5:0] == PWR_TABLE_ADDR) begin
              s_d.ph = RSA_PWR;
              if (wdata[HDR_DIR_BIT]) s_d.sh_out = pwr_q[s_q.pidx];
            end else if (wdata[HDR_BURST_BIT]) begin
              s_d.ph = RSA_STAT;
              s_d.sh_out = status_reg_val_i;
            end else begin
              // Command strobe: no data follows
              s_d.ph = RSA_HDR;
              if (wdata[5:0] == POWER_DOWN_STROBE) s_d.defer_pd = 1'b1;
              else if (wdata[5:0] == CRYSTAL_OFF_STROBE) s_d.defer_xo = 1'b1;
              else begin
                s_d.strobe = 1'b1;
                s_d.scode  = wdata[5:0];
                if (wdata[5:0] == FLUSH_TX_STROBE) s_d.flush = 1'b1;
                if (wdata[5:0] == SLEEP_REG_ADDR) s_d.sleep = 1'b1;
                if (wdata[5:0] != SLEEP_REG_ADDR) s_d.sleep = 1'b0;
                if (wdata[5:0] == CHIP_RESET_STROBE) begin
                  s_d.reset_busy = 1'b1;
                  s_d.busy_cnt   = 8'(RST_BUSY_CYC);
                end
              end
            end
          end
          RSA_CFG: begin
            if (!s_q.dir) cfg_we = 1'b1;
            if (s_q.burst) begin
              s_d.addr = s_q.addr + 6'h01;
              if (s_q.dir) s_d.sh_out = cfg_q[s_q.addr + 6'h01];
            end else s_d.ph = RSA_HDR;
          end
          RSA_FIFO: begin
            s_d.fifo_push = f_ready;
            s_d.fifo_byte = wdata;
            // Byte now being stored counts as used for the next status
            s_d.sh_out = status_byte(core_stable_i, main_state_i,
                                     f_cnt + ($clog2(FIFO_DEPTH)+1)'(f_ready));
            if (!s_q.burst) s_d.ph = RSA_HDR;
          end
          RSA_PWR: begin
            if (!s_q.dir) pwr_we = 1'b1;
            s_d.pidx = s_q.pidx + 3'h1;
            if (s_q.dir) s_d.sh_out = pwr_q[s_q.pidx + 3'h1];
            if (!s_q.burst) s_d.ph = RSA_HDR;
          end
          RSA_STAT: s_d.ph = RSA_IGNORE;
          default: s_d.ph = s_q.ph;
        endcase
        // First bit of the next byte stands from the end of this one
        s_d.so = s_d.reset_busy ? 1'b1 : s_d.sh_out[7];
      end
    end
    // Sleep entry flushes the FIFO
    if (s_d.sleep && !s_q.sleep) s_d.flush = 1'b1;
    s_d.plevel = pwr_q[cfg_q[0][2:0]];
  end

  // ===========================================================
  // Registers and storage
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.so <= 1'b1;
      s_q.sclk_s <= '0;
      s_q.sel_s <= 2'h3;
    end else begin
      s_q <= s_d;
    end
    if (cfg_we) cfg_q[s_q.addr] <= wdata;
    if (!nrst_i || sleep_entry) begin
      for (int i = 0; i < PWR_ENTRIES; i++) pwr_q[i] <= PWR_RESET;
    end else if (pwr_we) begin
      pwr_q[s_q.pidx] <= wdata;
    end
    if (!nrst_i) begin
      for (int j = 0; j < CFG_REGS; j++) cfg_q[j] <= CFG_RESET;
    end
  end

  // Outputs straight from flops
  assign shared_status_out_pin_o    = s_q.so;
  assign shared_status_out_pin_oe_o = s_q.oe;
  assign tx_valid_o          = s_q.tx_v;
  assign tx_data_o           = s_q.tx_d;
  assign power_index_field_o = s_q.pidx;
  assign power_level_o       = s_q.plevel;
  assign strobe_o            = s_q.strobe;
  assign strobe_code_o       = s_q.scode;
  assign sleep_o             = s_q.sleep;
  assign status_addr_o       = s_q.addr;

  // ===========================================================
  // Checks
  AST_OE_FOLLOWS_SELECT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !sel_n |=> s_q.oe) else $error("Output not driven while selected");
  AST_IDX_CLEAR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    sel_n |=> s_q.pidx == 3'h0) else $error("Table index not cleared");
  AST_FLUSH_ON_STROBE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (s_q.strobe && s_q.scode == FLUSH_TX_STROBE) |=> f_cnt == '0) else $error("Flush missed");
  AST_DEFER_PD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (s_q.strobe && s_q.scode == POWER_DOWN_STROBE) |-> $past(sel_n)) else $error("Power-down early");
  AST_SLEEP_TABLE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    sleep_entry |=> pwr_q[0] == PWR_RESET) else $error("Table kept in sleep");
  AST_IDX_STEP: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (pwr_we && !sel_n) |=> s_q.pidx == $past(s_q.pidx) + 3'h1) else $error("Index not stepped");
  AST_FIFO_WO: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (s_q.ph == RSA_FIFO) |-> !s_q.dir) else $error("FIFO entered on read");
  AST_BURST_ADDR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (cfg_we && s_q.burst) |=> s_q.addr == $past(s_q.addr) + 6'h01) else $error("Burst address stuck");
endmodule

// file: verif/rsa_spi_master.sv
// Purpose: Microcontroller model acting as master on the radio serial port
// Assumes: Mode 0, 125 ns serial clock made from the 200 MHz core clock
// Notes:   Lines change only after core clock rising edges
`timescale 1ns/100ps
module rsa_spi_master (
  // Clock
  input  wire logic core_clk_i,
  // Serial pins
  output logic      sclk_o,
  output logic      select_low_o,
  output logic      sdi_o,
  input  wire logic so_i
);
  // Extra low cycles per bit, for a slow master
  int slow = 0;
  // Ready waits that ran out of time
  int fails = 0;
  // ============================================================
  // Idle levels: serial clock stands still outside frames
  initial begin
    sclk_o       = 1'b0;
    select_low_o = 1'b1;
    sdi_o        = 1'b0;
  end
  // Bounded wait for the ready flag low on the serial output
  task automatic wait_ready();
    for (int n = 0; n < 200 && so_i !== 1'b0; n++) @(posedge core_clk_i);
    if (so_i !== 1'b0) fails++;
  endtask
  // Open a frame
  task automatic start();
    @(posedge core_clk_i);
    select_low_o <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    wait_ready();
  endtask
  // One byte, MSB first; input sampled at each rising serial clock
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk_o <= 1'b0;
      sdi_o  <= tx[i];
      repeat (12 + slow) @(posedge core_clk_i);
      sclk_o <= 1'b1;
      rx[i] = so_i;
      repeat (13) @(posedge core_clk_i);
    end
  endtask
  // Close a frame; a released data line shows the inverse of its last bit
  task automatic stop();
    sclk_o <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    select_low_o <= 1'b1;
    sdi_o        <= ~sdi_o;
    repeat (12) @(posedge core_clk_i);
  endtask
endmodule

// file: verif/tb_radio_spi_register_access.sv
// Purpose: Self-checking bench of the radio serial register port
// Assumes: FIFO depth cut to 16 for short runs
// Notes:   Status byte expected from stable core, state 2, tracked free space
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_radio_spi_register_access;
  import rsa_pkg::*;
  localparam int DEPTH = 16;
  logic       core_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       sclk, select_low, sdi, so, so_oe, tx_valid, strobe, sleep;
  logic       tx_ready = 1'b0;
  logic       core_stable = 1'b1;
  logic [7:0] tx_data, plevel;
  logic [2:0] pidx;
  logic [5:0] strobe_code, status_addr;
  logic [5:0] last_code = 6'h00;
  int         miscompares = 0;
  int         checks = 0;
  int         strobe_cnt = 0;
  // ============================================================
  // Clock, design and master
  always #2.5 core_clk = ~core_clk;
  rsa_spi_port #(.FIFO_DEPTH(DEPTH)) i_dut (
    .core_clk_i(core_clk), .nrst_i(nrst), .sclk_i(sclk), .select_low_i(select_low), .sdi_i(sdi),
    .shared_status_out_pin_o(so), .shared_status_out_pin_oe_o(so_oe), .core_stable_i(core_stable),
    .main_state_i(3'h2), .status_reg_val_i(8'h6c), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .tx_data_o(tx_data), .power_index_field_o(pidx), .power_level_o(plevel), .strobe_o(strobe),
    .strobe_code_o(strobe_code), .sleep_o(sleep), .status_addr_o(status_addr));
  // A released output line shows the inverse of its last value
  rsa_spi_master i_master (.core_clk_i(core_clk), .sclk_o(sclk), .select_low_o(select_low),
    .sdi_o(sdi), .so_i(so_oe ? so : ~so));
  // Strobe pulse log
  always @(posedge core_clk) begin
    if (strobe === 1'b1) begin
      strobe_cnt++;
      last_code = strobe_code;
    end
  end
  // ============================================================
  // Helpers
  function automatic logic [7:0] st(int used);
    int f;
    f = DEPTH - used;
    return {1'b0, 3'h2, (f > 15) ? FREE_SAT : f[3:0]};
  endfunction
  task automatic xs(input logic [7:0] tx, input logic [7:0] ex, input string nm);
    logic [7:0] r;
    i_master.xfer(tx, r);
    `CHK(nm, ex, r)
  endtask
  task automatic rd(input logic [7:0] hdr, input logic [7:0] ex, input string nm);
    i_master.start();
    xs(hdr, st(0), "read header");
    xs(8'h00, ex, nm);
    i_master.stop();
  endtask
  // ============================================================
  // Scenarios
  task automatic t_cfg();
    i_master.start();
    `CHK("oe while selected", 1'b1, so_oe)
    xs(8'h05, st(0), "write header");
    xs(8'ha5, st(0), "write data");
    i_master.stop();
    `CHK("oe released", 1'b0, so_oe)
    rd(8'h85, 8'ha5, "single read");
    i_master.start();
    xs(8'h41, st(0), "burst write header");
    for (int k = 1; k < 4; k++) xs(8'h11 * k[7:0], st(0), "burst write");
    i_master.stop();
    i_master.start();
    xs(8'hc1, st(0), "burst read header");
    for (int k = 1; k < 4; k++) xs(8'h00, 8'h11 * k[7:0], "burst read");
    i_master.stop();
    $display("t_cfg done");
  endtask
  task automatic t_pwr();
    i_master.start();
    xs(8'h7e, st(0), "table write header");
    for (int k = 0; k < 9; k++) xs(8'h80 + k[7:0], st(0), "table write");
    `CHK("index wrapped", 3'h1, pidx)
    i_master.stop();
    `CHK("index cleared", 3'h0, pidx)
    i_master.start();
    xs(8'hfe, st(0), "table read header");
    for (int k = 0; k < 8; k++) xs(8'h00, (k == 0) ? 8'h88 : 8'h80 + k[7:0], "table read");
    i_master.stop();
    i_master.start();
    xs(8'h00, st(0), "cfg0 header");
    xs(8'h03, st(0), "cfg0 data");
    xs(8'h3e, st(0), "table single header");
    xs(8'h5a, st(0), "table single data");
    i_master.stop();
    `CHK("power level", 8'h83, plevel)
    rd(8'hbe, 8'h5a, "table single read");
    $display("t_pwr done");
  endtask
  task automatic t_fifo();
    int got;
    i_master.slow = 20;
    i_master.start();
    xs(8'h7f, st(0), "fifo burst header");
    for (int k = 0; k <= DEPTH; k++) xs(8'h40 + k[7:0], st(k), "fifo free space");
    i_master.stop();
    i_master.slow = 0;
    tx_ready <= 1'b1;
    got = 0;
    for (int n = 0; n < 400 && got < DEPTH; n++) begin
      @(posedge core_clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        `CHK("fifo order", 8'h40 + got[7:0], tx_data)
        got++;
      end
    end
    `CHK("fifo drained", DEPTH, got)
    tx_ready <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK("full write dropped", 1'b0, tx_valid)
    i_master.start();
    xs(8'h3f, st(0), "single header");
    xs(8'haa, st(0), "single data");
    xs(8'h3f, st(1), "second header");
    xs(8'hbb, st(1), "second data");
    xs({2'b00, FLUSH_TX_STROBE}, st(2), "flush header");
    xs({2'b00, FLUSH_TX_STROBE}, st(0), "after flush");
    i_master.stop();
    tx_ready <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHK("fifo flushed", 1'b0, tx_valid)
    tx_ready <= 1'b0;
    $display("t_fifo done");
  endtask
  task automatic t_strobe();
    i_master.start();
    xs({2'b00, CHIP_RESET_STROBE}, st(0), "reset strobe status");
    `CHK("busy after reset", 1'b1, so)
    i_master.wait_ready();
    `CHK("ready after reset", 1'b0, so)
    xs({2'b00, FLUSH_TX_STROBE}, st(0), "flush strobe status");
    `CHK("strobe code", FLUSH_TX_STROBE, last_code)
    core_stable <= 1'b0;
    xs({2'b00, FLUSH_TX_STROBE}, st(0) | 8'h80, "not ready flag");
    core_stable <= 1'b1;
    xs({2'b11, 6'h31}, st(0), "status reg header");
    xs(8'h00, 8'h6c, "status reg value");
    `CHK("status address", 6'h31, status_addr)
    i_master.stop();
    $display("t_strobe done");
  endtask
  task automatic t_sleep();
    int n0;
    n0 = strobe_cnt;
    i_master.start();
    xs({2'b00, CRYSTAL_OFF_STROBE}, st(0), "crystal-off status");
    `CHK("crystal-off deferred", n0, strobe_cnt)
    i_master.stop();
    `CHK("crystal-off at release", n0 + 1, strobe_cnt)
    `CHK("crystal-off code", CRYSTAL_OFF_STROBE, last_code)
    `CHK("awake after crystal-off", 1'b0, sleep)
    n0 = strobe_cnt;
    i_master.start();
    xs({2'b00, POWER_DOWN_STROBE}, st(0), "power-down status");
    `CHK("power-down deferred", n0, strobe_cnt)
    i_master.stop();
    `CHK("power-down at release", n0 + 1, strobe_cnt)
    `CHK("power-down code", POWER_DOWN_STROBE, last_code)
    i_master.start();
    xs({2'b00, SLEEP_REG_ADDR}, st(0), "sleep status");
    i_master.stop();
    `CHK("sleep entered", 1'b1, sleep)
    rd(8'hbe, PWR_RESET, "table lost");
    $display("t_sleep done");
  endtask
  // ============================================================
  // Verdict
  task automatic end_of_test();
    miscompares += i_master.fails;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge core_clk);
    t_cfg();
    t_pwr();
    t_fifo();
    t_strobe();
    t_sleep();
    end_of_test();
  end
endmodule
